// ### design/tsw_pkg.sv
`default_nettype none
package tsw_pkg;
  // -------------------------------------------------------------
  // highway geometry
  // -------------------------------------------------------------
  localparam int NUM_HW = 12;
  localparam int SLOTS = 32;
  localparam int NUM_CH = NUM_HW * SLOTS;
  localparam int NUM_SPAN = 2;
  localparam int NUM_BUS = 8;
  localparam int HW_BUS0 = 2;
  localparam int HW_AUX = 10;
  localparam int HW_CTL = 11;
  localparam int ES_DEPTH = 64;
  localparam logic [7:0] IDLE_BYTE = 8'hff;
  // -------------------------------------------------------------
  // reference sources
  // -------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_SPAN0 = 3'b000,
    SRC_SPAN1 = 3'b001,
    SRC_BUSF = 3'b010,
    SRC_BUSSEC = 3'b011,
    SRC_EXTF = 3'b100,
    SRC_EXTBIT = 3'b101,
    SRC_OSC = 3'b110
  } src_t;
  localparam src_t SEL_RST = SRC_OSC;
  // -------------------------------------------------------------
  // register map
  // -------------------------------------------------------------
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_IRQ_STAT = 5'h08;
  localparam logic [4:0] REG_IRQ_MASK = 5'h0c;
  localparam logic [4:0] REG_CONN_IDX = 5'h10;
  localparam logic [4:0] REG_CONN_DATA = 5'h14;
  localparam int CONN_W = 18;
  localparam int CONN_CONST = 17;
  localparam int CONN_SRC = 8;
  localparam logic [17:0] CONN_RST = 18'h200ff;
  localparam int IRQ_W = 4;
  localparam int IRQ_LOST = 0;
  localparam int IRQ_FALL = 1;
  localparam int IRQ_SLIP0 = 2;
  localparam logic [3:0] IRQ_RST = 4'h0;
  localparam int ST_ACT = 0;
  localparam int ST_FALLEN = 3;
  localparam int ST_LOS = 4;
  // -------------------------------------------------------------
  // timing
  // -------------------------------------------------------------
  localparam longint CLK_HZ = 250000000;
  localparam longint HW_BIT_HZ = 2048000;
  localparam int NCO_W = 24;
  localparam logic [23:0] NCO_INC =
    24'((HW_BIT_HZ * (longint'(1) << NCO_W)) / CLK_HZ);
  localparam longint FRAME_LOSS_US = 250;
  localparam longint BIT_LOSS_NS = 2000;
  localparam int FRAME_LOSS_CYC = int'((FRAME_LOSS_US * CLK_HZ) / 1000000);
  localparam int BIT_LOSS_CYC = int'((BIT_LOSS_NS * CLK_HZ) / 1000000000);
  localparam int WD_W = 17;
  // -------------------------------------------------------------
  // synchroniser vector positions
  // -------------------------------------------------------------
  localparam int SY_SCLK = 0;
  localparam int SY_SDAT = 2;
  localparam int SY_SFRM = 4;
  localparam int SY_LOS = 6;
  localparam int SY_BUS = 8;
  localparam int SY_AUX = 16;
  localparam int SY_CTL = 17;
  localparam int SY_BFRM = 18;
  localparam int SY_BSEC = 19;
  localparam int SY_EFRM = 20;
  localparam int SY_EBIT = 21;
  localparam int SYNC_W = 22;
endpackage
`default_nettype wire

// ### design/tdm_timeslot_switch.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - each highway is a 2.048 Mbit/s serial stream of 32 byte slots
// - twelve highways: two spans, eight bus streams, aux, control
// - any input slot routes to any output slot, set by software
// - one input slot may feed many output slots at once
// - an output slot may carry a constant byte every frame
// - constant byte repeats in hardware with no per-frame software
// - all highways timed from one software-selected reference
// - references include both span frames and both bus 8 kHz clocks
// - references include external frame, external bit clock, oscillator
// - lost reference falls back; a lost span moves to the other span, or to the oscillator if that span has LOS
// - second span lost after fallback goes to the oscillator
// - lost bus or external reference goes straight to oscillator
// - timing span is synchronous; the other span may be asynchronous
// - each received span passes a 64 by 8 elastic store
// - elastic store aligns span slots to highway frame timing
// - on slip one whole received frame is dropped or repeated, then forwarding goes on
// - bus side has eight streams, each with own input and output line
module tdm_timeslot_switch
  import tsw_pkg::*;
#(
  parameter int FRAME_LOSS = FRAME_LOSS_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  input wire logic [1:0] span_rx_clk_i,
  input wire logic [1:0] span_rx_data_i,
  input wire logic [1:0] span_rx_frame_i,
  input wire logic [1:0] span_los_i,
  output logic [1:0] span_highway_tx_o,
  input wire logic [7:0] bus_stream_in_i,
  output logic [7:0] bus_stream_out_o,
  input wire logic aux_in_i,
  output logic aux_out_o,
  input wire logic ctrl_in_i,
  output logic ctrl_out_o,
  input wire logic bus_frame_i,
  input wire logic bus_sec8k_i,
  input wire logic ext_frame_i,
  input wire logic ext_bit_clk_i,
  output logic hw_bit_clk_o,
  output logic hw_frame_o
);
  // -------------------------------------------------------------
  // functions
  // -------------------------------------------------------------
  function automatic logic ref_rise(input src_t s,
                                    input logic [SYNC_W-1:0] r);
    case (s)
      SRC_SPAN0: ref_rise = r[SY_SFRM];
      SRC_SPAN1: ref_rise = r[SY_SFRM+1];
      SRC_BUSF: ref_rise = r[SY_BFRM];
      SRC_BUSSEC: ref_rise = r[SY_BSEC];
      SRC_EXTF: ref_rise = r[SY_EFRM];
      SRC_EXTBIT: ref_rise = r[SY_EBIT];
      default: ref_rise = 1'b0;
    endcase
  endfunction

  function automatic logic [8:0] chan(input int h, input logic [4:0] s);
    chan = 9'(h * SLOTS) + {4'h0, s};
  endfunction

  // -------------------------------------------------------------
  // input synchronisers
  // -------------------------------------------------------------
  logic [SYNC_W-1:0] async_in;
  logic [SYNC_W-1:0] meta_ff;
  logic [SYNC_W-1:0] sync_ff;
  logic [SYNC_W-1:0] prev_ff;
  logic [SYNC_W-1:0] rise;
  assign async_in = {ext_bit_clk_i, ext_frame_i, bus_sec8k_i,
                     bus_frame_i, ctrl_in_i, aux_in_i, bus_stream_in_i,
                     span_los_i, span_rx_frame_i, span_rx_data_i,
                     span_rx_clk_i};
  assign rise = sync_ff & ~prev_ff;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
      prev_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // -------------------------------------------------------------
  // bus slave decode
  // -------------------------------------------------------------
  logic wait_ff;
  logic wr_acc;
  logic rd_prep;
  logic sel_wr;
  assign wr_acc = avs_write_i & ~wait_ff;
  assign rd_prep = avs_read_i & wait_ff;
  assign sel_wr = wr_acc && avs_address_i == REG_CTRL &&
                  avs_writedata_i[2:0] <= SRC_OSC;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= ~((avs_read_i | avs_write_i) & wait_ff);
    end
  end

  // -------------------------------------------------------------
  // reference selection and fallback
  // -------------------------------------------------------------
  src_t sel_ff;
  src_t act_ff;
  src_t nxt_act;
  logic [WD_W-1:0] wd_ff;
  logic wd_hit;
  logic loss;
  logic fell;
  logic [IRQ_W-1:0] ev;
  logic [NUM_SPAN-1:0] slip;
  assign wd_hit = act_ff == SRC_EXTBIT ? wd_ff >= WD_W'(BIT_LOSS_CYC)
                                       : wd_ff >= WD_W'(FRAME_LOSS);

  always_comb begin
    nxt_act = act_ff;
    fell = 1'b0;
    case (act_ff)
      SRC_SPAN0: loss = sync_ff[SY_LOS] | wd_hit;
      SRC_SPAN1: loss = sync_ff[SY_LOS+1] | wd_hit;
      SRC_OSC: loss = 1'b0;
      default: loss = wd_hit;
    endcase
    if (sel_wr) begin
      nxt_act = src_t'(avs_writedata_i[2:0]);
    end else if (loss) begin
      fell = 1'b1;
      case (act_ff)
        SRC_SPAN0: nxt_act = (sync_ff[SY_LOS+1] || act_ff != sel_ff) ?
                             SRC_OSC : SRC_SPAN1;
        SRC_SPAN1: nxt_act = (sync_ff[SY_LOS] || act_ff != sel_ff) ?
                             SRC_OSC : SRC_SPAN0;
        default: nxt_act = SRC_OSC;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sel_ff <= SEL_RST;
      act_ff <= SEL_RST;
    end else begin
      if (sel_wr) begin
        sel_ff <= src_t'(avs_writedata_i[2:0]);
      end
      act_ff <= nxt_act;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wd_ff <= '0;
    end else if (act_ff != nxt_act || ref_rise(act_ff, rise)) begin
      wd_ff <= '0;
    end else if (!wd_hit) begin
      wd_ff <= wd_ff + 1'b1;
    end
  end

  // slip pair, fallback, selected reference lost
  assign ev = {slip, fell, loss & (act_ff == sel_ff) & ~sel_wr};

  // -------------------------------------------------------------
  // highway timing
  // -------------------------------------------------------------
  logic [NCO_W-1:0] nco_ff;
  logic [NCO_W:0] nco_sum;
  logic [7:0] bit_pos_ff;
  logic align;
  logic bit_tick;
  logic last;
  logic frame_wrap;
  logic [4:0] slot;
  logic [4:0] nslot;
  logic hw_bit_clk_ff;
  logic hw_frame_ff;
  assign nco_sum = {1'b0, nco_ff} + {1'b0, NCO_INC};
  assign align = ref_rise(act_ff, rise) && act_ff != SRC_EXTBIT;
  assign bit_tick = act_ff == SRC_EXTBIT ? rise[SY_EBIT]
                                         : nco_sum[NCO_W];
  assign slot = bit_pos_ff[7:3];
  assign nslot = slot + 5'h01;
  assign last = bit_pos_ff[2:0] == 3'h7;
  assign frame_wrap = bit_tick && bit_pos_ff == 8'hff;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      nco_ff <= '0;
      bit_pos_ff <= 8'h00;
    end else begin
      nco_ff <= align ? '0 : nco_sum[NCO_W-1:0];
      if (align) begin
        bit_pos_ff <= 8'h00;
      end else if (bit_tick) begin
        bit_pos_ff <= bit_pos_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hw_bit_clk_ff <= 1'b0;
      hw_frame_ff <= 1'b0;
    end else begin
      hw_bit_clk_ff <= act_ff == SRC_EXTBIT ? sync_ff[SY_EBIT]
                                            : nco_ff[NCO_W-1];
      hw_frame_ff <= bit_pos_ff == 8'h00;
    end
  end

  // -------------------------------------------------------------
  // elastic receive stores
  // -------------------------------------------------------------
  logic [7:0] es_mem [NUM_SPAN][ES_DEPTH];
  logic [7:0] sp_pos_ff [NUM_SPAN];
  logic [7:0] sp_sh_ff [NUM_SPAN];
  logic [NUM_SPAN-1:0] wr_half_ff;
  logic [NUM_SPAN-1:0] rd_half_ff;
  logic [7:0] sp_at [NUM_SPAN];
  logic [7:0] sp_byte [NUM_SPAN];

  always_comb begin
    for (int s = 0; s < NUM_SPAN; s++) begin
      sp_at[s] = sync_ff[SY_SFRM+s] ? 8'h00 : sp_pos_ff[s];
      sp_byte[s] = {sp_sh_ff[s][6:0], sync_ff[SY_SDAT+s]};
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_half_ff <= '0;
      for (int s = 0; s < NUM_SPAN; s++) begin
        sp_pos_ff[s] <= 8'h00;
        sp_sh_ff[s] <= 8'h00;
      end
    end else begin
      for (int s = 0; s < NUM_SPAN; s++) begin
        if (rise[SY_SCLK+s]) begin
          sp_sh_ff[s] <= sp_byte[s];
          sp_pos_ff[s] <= sp_at[s] + 8'h01;
          if (sp_at[s] == 8'hff) begin
            wr_half_ff[s] <= ~wr_half_ff[s];
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    for (int s = 0; s < NUM_SPAN; s++) begin
      if (rise[SY_SCLK+s] && sp_at[s][2:0] == 3'h7) begin
        es_mem[s][{wr_half_ff[s], sp_at[s][7:3]}] <= sp_byte[s];
      end
    end
  end

  always_comb begin
    for (int s = 0; s < NUM_SPAN; s++) begin
      slip[s] = frame_wrap && (~wr_half_ff[s] == rd_half_ff[s]);
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_half_ff <= '0;
    end else if (frame_wrap) begin
      rd_half_ff <= ~wr_half_ff;
    end
  end

  // -------------------------------------------------------------
  // connection and data memories
  // -------------------------------------------------------------
  logic [CONN_W-1:0] conn_ff [NUM_CH];
  logic [7:0] dmem [NUM_CH];
  logic [8:0] conn_idx_ff;
  logic [NUM_HW-1:0] hin;
  logic [7:0] in_sh_ff [NUM_HW];
  logic [7:0] fetch [NUM_HW];
  logic [8:0] src [NUM_HW];
  logic [NUM_HW-1:0] is_const;
  assign hin = {sync_ff[SY_CTL], sync_ff[SY_AUX],
                sync_ff[SY_BUS+:NUM_BUS], 2'b00};

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      conn_idx_ff <= 9'h000;
      for (int i = 0; i < NUM_CH; i++) begin
        conn_ff[i] <= CONN_RST;
      end
    end else if (wr_acc) begin
      if (avs_address_i == REG_CONN_IDX) begin
        conn_idx_ff <= avs_writedata_i[8:0];
      end
      if (avs_address_i == REG_CONN_DATA &&
          conn_idx_ff < 9'(NUM_CH)) begin
        conn_ff[conn_idx_ff] <= avs_writedata_i[CONN_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (bit_tick && last) begin
      for (int s = 0; s < NUM_SPAN; s++) begin
        dmem[chan(s, slot)] <= es_mem[s][{rd_half_ff[s], slot}];
      end
      for (int h = HW_BUS0; h < NUM_HW; h++) begin
        dmem[chan(h, slot)] <= {in_sh_ff[h][6:0], hin[h]};
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int h = 0; h < NUM_HW; h++) begin
        in_sh_ff[h] <= 8'h00;
      end
    end else if (bit_tick) begin
      for (int h = HW_BUS0; h < NUM_HW; h++) begin
        in_sh_ff[h] <= {in_sh_ff[h][6:0], hin[h]};
      end
    end
  end

  // -------------------------------------------------------------
  // output slot fetch and serialisers
  // -------------------------------------------------------------
  always_comb begin
    for (int h = 0; h < NUM_HW; h++) begin
      src[h] = conn_ff[chan(h, nslot)][CONN_SRC+:9];
      is_const[h] = conn_ff[chan(h, nslot)][CONN_CONST];
      if (is_const[h]) begin
        fetch[h] = conn_ff[chan(h, nslot)][7:0];
      end else if (src[h] < 9'(NUM_CH)) begin
        fetch[h] = dmem[src[h]];
      end else begin
        fetch[h] = IDLE_BYTE;
      end
    end
  end

  logic [7:0] out_sh_ff [NUM_HW];
  logic [NUM_HW-1:0] hw_out_ff;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hw_out_ff <= '1;
      for (int h = 0; h < NUM_HW; h++) begin
        out_sh_ff[h] <= IDLE_BYTE;
      end
    end else if (bit_tick) begin
      for (int h = 0; h < NUM_HW; h++) begin
        if (last) begin
          out_sh_ff[h] <= fetch[h];
          hw_out_ff[h] <= fetch[h][7];
        end else begin
          out_sh_ff[h] <= {out_sh_ff[h][6:0], 1'b1};
          hw_out_ff[h] <= out_sh_ff[h][6];
        end
      end
    end
  end

  assign span_highway_tx_o = hw_out_ff[NUM_SPAN-1:0];
  assign bus_stream_out_o = hw_out_ff[HW_BUS0+:NUM_BUS];
  assign aux_out_o = hw_out_ff[HW_AUX];
  assign ctrl_out_o = hw_out_ff[HW_CTL];
  assign hw_bit_clk_o = hw_bit_clk_ff;
  assign hw_frame_o = hw_frame_ff;

  // -------------------------------------------------------------
  // interrupt status and mask
  // -------------------------------------------------------------
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic [IRQ_W-1:0] irq_clr;
  logic irq_ff;
  assign irq_clr = (wr_acc && avs_address_i == REG_IRQ_STAT) ?
                   avs_writedata_i[IRQ_W-1:0] : '0;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat_ff <= IRQ_RST;
      irq_mask_ff <= IRQ_RST;
      irq_ff <= 1'b0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | ev;
      if (wr_acc && avs_address_i == REG_IRQ_MASK) begin
        irq_mask_ff <= avs_writedata_i[IRQ_W-1:0];
      end
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  assign irq_o = irq_ff;

  // -------------------------------------------------------------
  // read data
  // -------------------------------------------------------------
  logic [31:0] rdata_ff;
  logic [31:0] status;
  always_comb begin
    status = 32'h0;
    status[ST_ACT+:3] = act_ff;
    status[ST_FALLEN] = act_ff != sel_ff;
    status[ST_LOS+:NUM_SPAN] = sync_ff[SY_LOS+:NUM_SPAN];
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_ff <= 32'h0;
    end else if (rd_prep) begin
      case (avs_address_i)
        REG_CTRL: rdata_ff <= {29'h0, sel_ff};
        REG_STATUS: rdata_ff <= status;
        REG_IRQ_STAT: rdata_ff <= {28'h0, irq_stat_ff};
        REG_IRQ_MASK: rdata_ff <= {28'h0, irq_mask_ff};
        REG_CONN_IDX: rdata_ff <= {23'h0, conn_idx_ff};
        REG_CONN_DATA: rdata_ff <= conn_idx_ff < 9'(NUM_CH) ?
                                   {14'h0, conn_ff[conn_idx_ff]} : 32'h0;
        default: rdata_ff <= 32'h0;
      endcase
    end
  end

  assign avs_readdata_o = rdata_ff;
  assign avs_waitrequest_o = wait_ff;
endmodule
`default_nettype wire

// ### tb/tsw_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tsw_chk
  import tsw_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic irq_o,
  input wire logic hw_bit_clk_o,
  input wire logic hw_frame_o
);
  logic [7:0] hi_cnt_ff;
  logic [7:0] frm_cnt_ff;
  logic [15:0] gap_cnt_ff;

  // run length of bit clock high phase
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) hi_cnt_ff <= 8'h00;
    else hi_cnt_ff <= hw_bit_clk_o ? hi_cnt_ff + 8'h01 : 8'h00;
  end

  // run length of frame marker
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) frm_cnt_ff <= 8'h00;
    else frm_cnt_ff <= hw_frame_o ? frm_cnt_ff + 8'h01 : 8'h00;
  end

  // cycles since frame marker
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) gap_cnt_ff <= 16'h0000;
    else gap_cnt_ff <= hw_frame_o ? 16'h0000 : gap_cnt_ff + 16'h0001;
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_answer;
    ##1 !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  sequence s_rd_done;
    avs_read_i && !avs_waitrequest_o;
  endsequence

  a_req_answer: assert property (
    $rose(avs_read_i || avs_write_i) |-> s_answer)
    else $error("request not answered in one cycle");
  a_ack_needs_req: assert property (
    !avs_waitrequest_o |-> (avs_read_i || avs_write_i))
    else $error("waitrequest low without request");
  a_unmapped_zero: assert property (
    s_rd_done ##0 (avs_address_i[4:3] == 2'b11) |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_irq_upper_zero: assert property (
    s_rd_done ##0 (avs_address_i[4:3] == 2'b01)
    |-> avs_readdata_o[31:IRQ_W] == '0)
    else $error("irq register upper bits set");
  a_mask_off_irq: assert property (
    avs_write_i && !avs_waitrequest_o && avs_address_i == REG_IRQ_MASK
    && avs_writedata_i[3:0] == 4'h0 |-> ##2 !irq_o [*3])
    else $error("irq high with mask cleared");
  a_frame_width: assert property (frm_cnt_ff <= 8'h7c)
    else $error("frame marker longer than one bit");
  a_frame_space: assert property (
    $rose(hw_frame_o) |-> gap_cnt_ff <= 16'h7d00)
    else $error("frame longer than 256 bits");
  a_bit_half: assert property (hi_cnt_ff <= 8'h3e)
    else $error("bit clock high phase too long");
endmodule

bind tdm_timeslot_switch tsw_chk i_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o),
  .hw_bit_clk_o(hw_bit_clk_o), .hw_frame_o(hw_frame_o));
`default_nettype wire

// ### tb/span_src.sv
`timescale 1ns/1ps
`default_nettype none
module span_src (
  output logic [1:0] clk_o,
  output logic [1:0] data_o,
  output logic [1:0] frame_o
);
  logic [7:0] pos;
  logic [7:0] b0;
  logic [7:0] b1;

  // two spans on a free 160 ns clock, data changes on falling edge
  initial begin
    clk_o = 2'b00;
    pos = 8'h00;
    forever begin
      b0 = 8'h40 + {3'h0, pos[7:3]};
      b1 = 8'h80 + {3'h0, pos[7:3]};
      data_o = {b1[~pos[2:0]], b0[~pos[2:0]]};
      frame_o = {2{pos == 8'h00}};
      #80 clk_o = 2'b11;
      #80 clk_o = 2'b00;
      pos = pos + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import tsw_pkg::*;
;
  logic sys_clk_i;
  logic rst_i;
  logic [4:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic irq_o;
  logic bus_frame_i;
  logic ext_bit_clk_i;
  logic [1:0] span_los_i;
  logic [1:0] span_clk;
  logic [1:0] span_dat;
  logic [1:0] span_frm;
  logic [1:0] span_tx;
  logic [7:0] bus_out;
  logic aux_out;
  logic ctrl_out;
  logic hw_frame;
  logic [11:0] hw_out;
  logic [11:0] cap [256];
  logic [31:0] q;
  int mismatches;
  int checks_done;
  int n;
  logic [4:0] ra [6] = '{REG_CTRL, REG_STATUS, REG_IRQ_STAT, REG_IRQ_MASK,
    REG_CONN_IDX, 5'h18};
  logic [31:0] rm [6] = '{'1, '1, 32'h3, '1, '1, '1};
  logic [31:0] re [6] = '{32'(SEL_RST), 32'(SEL_RST), 32'h0, 32'h0, 32'h0,
    32'h0};
  logic [31:0] ci [4] = '{32'h45, 32'h9, 32'h120, 32'h147};
  logic [31:0] cd [4] = '{32'h00300, 32'h00300, 32'h02400, 32'h200a5};
  logic [31:0] fs [2] = '{32'h2, 32'h5};

  assign hw_out = {ctrl_out, aux_out, bus_out, span_tx};
  span_src i_src (.clk_o(span_clk), .data_o(span_dat), .frame_o(span_frm));
  tdm_timeslot_switch #(.FRAME_LOSS(10500)) i_dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o),
    .span_rx_clk_i(span_clk), .span_rx_data_i(span_dat),
    .span_rx_frame_i(span_frm), .span_los_i(span_los_i),
    .span_highway_tx_o(span_tx), .bus_stream_in_i({8{span_dat[0]}}),
    .bus_stream_out_o(bus_out), .aux_in_i(span_dat[1]), .aux_out_o(aux_out),
    .ctrl_in_i(span_dat[0]), .ctrl_out_o(ctrl_out), .bus_frame_i(bus_frame_i),
    .bus_sec8k_i(span_frm[1]), .ext_frame_i(span_frm[0]),
    .ext_bit_clk_i(ext_bit_clk_i), .hw_bit_clk_o(), .hw_frame_o(hw_frame));

  task automatic end_of_test();
    if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask

  // one bus access, held until waitrequest is seen low
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge sys_clk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 20);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge sys_clk_i);
    if (k >= 20) begin
      mismatches++;
      end_of_test();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, q & m);
  endtask

  task automatic irq_chk(input logic e);
    repeat (2) @(posedge sys_clk_i);
    chk("irq", 32'(e), 32'(irq_o));
  endtask

  // capture one highway frame, sampled mid-bit
  task automatic grab();
    n = 0;
    while (hw_frame !== 1'b0 && n < 40000) begin
      @(posedge sys_clk_i);
      n++;
    end
    while (hw_frame !== 1'b1 && n < 40000) begin
      @(posedge sys_clk_i);
      n++;
    end
    if (n >= 40000) begin
      mismatches++;
      end_of_test();
    end
    repeat (61) @(posedge sys_clk_i);
    for (int k = 0; k < 256; k++) begin
      cap[k] = hw_out;
      repeat (122) @(posedge sys_clk_i);
    end
  endtask

  function automatic logic [7:0] slot_byte(input int h, input int s);
    for (int b = 0; b < 8; b++) slot_byte[7-b] = cap[8*s+b][h];
  endfunction

  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    rst_i = 1'b1;
    avs_address_i = 5'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    bus_frame_i = 1'b0;
    ext_bit_clk_i = 1'b0;
    span_los_i = 2'b00;
    mismatches = 0;
    checks_done = 0;
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    foreach (ra[i]) rd(ra[i], rm[i], re[i]);
    rd(REG_CONN_DATA, '1, 32'(CONN_RST));
    foreach (ci[i]) begin
      wr(REG_CONN_IDX, ci[i]);
      wr(REG_CONN_DATA, cd[i]);
    end
    rd(REG_CONN_DATA, '1, 32'h200a5);
    wr(REG_CONN_IDX, 32'h180);
    wr(REG_CONN_DATA, 32'h200aa);
    rd(REG_CONN_DATA, '1, 32'h0);
    wr(REG_CTRL, 32'h7);
    rd(REG_CTRL, '1, 32'(SEL_RST));
    grab();
    chk("hw2 slot5", 32'h43, 32'(slot_byte(2, 5)));
    chk("hw0 slot9", 32'h43, 32'(slot_byte(0, 9)));
    chk("hw9 slot0", 32'h84, 32'(slot_byte(9, 0)));
    chk("hw10 slot7", 32'ha5, 32'(slot_byte(10, 7)));
    chk("hw2 slot6", 32'hff, 32'(slot_byte(2, 6)));
    chk("hw1 slot3", 32'hff, 32'(slot_byte(1, 3)));
    chk("hw11 slot0", 32'hff, 32'(slot_byte(11, 0)));
    span_los_i <= 2'b01;
    wr(REG_CTRL, 32'h0);
    repeat (8) @(posedge sys_clk_i);
    rd(REG_STATUS, '1, 32'h19);
    rd(REG_IRQ_STAT, 32'h3, 32'h3);
    irq_chk(1'b0);
    wr(REG_IRQ_MASK, 32'h3);
    irq_chk(1'b1);
    wr(REG_IRQ_STAT, 32'h3);
    irq_chk(1'b0);
    span_los_i <= 2'b11;
    repeat (8) @(posedge sys_clk_i);
    rd(REG_STATUS, '1, 32'h3e);
    rd(REG_IRQ_STAT, 32'h3, 32'h2);
    irq_chk(1'b1);
    wr(REG_IRQ_MASK, 32'h0);
    irq_chk(1'b0);
    span_los_i <= 2'b00;
    repeat (8) @(posedge sys_clk_i);
    for (int s = 0; s < 7; s++) begin
      wr(REG_CTRL, 32'(s));
      rd(REG_STATUS, '1, 32'(s));
    end
    wr(REG_CTRL, 32'h0);
    repeat (10800) @(posedge sys_clk_i);
    rd(REG_STATUS, '1, 32'h0);
    wr(REG_IRQ_STAT, 32'h3);
    foreach (fs[i]) begin
      wr(REG_CTRL, fs[i]);
      n = 0;
      do begin
        acc(1'b0, REG_STATUS, 32'h0);
        n++;
      end while (q[2:0] !== 3'h6 && n < 6000);
      chk("fallback", 32'he, q);
      if (n >= 6000) end_of_test();
    end
    rd(REG_IRQ_STAT, 32'h3, 32'h3);
    rd(REG_IRQ_STAT, 32'hc, 32'hc);
    end_of_test();
  end
endmodule
`default_nettype wire
